// File: src/ipsf_pkg.sv
// shared constants for the serial port status flag block
package ipsf_pkg;
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS   = 8'h08;
  localparam logic [7:0] ADDR_OFS   = 8'h0C;
  // control register fields
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_TEN    = 1;
  localparam int CTRL_ACKV   = 2;
  localparam int CTRL_EN_LSB = 4;
  localparam int EN_W        = 5;
  // enable order inside the enable field
  localparam int EN_START = 0;
  localparam int EN_RSTRT = 1;
  localparam int EN_STOP  = 2;
  localparam int EN_RCV   = 3;
  localparam int EN_ACK   = 4;
  // status register fields
  localparam int ST_BF     = 0;
  localparam int ST_UA     = 1;
  localparam int ST_RW     = 2;
  localparam int ST_ACTIVE = 3;
  localparam int ST_STOP   = 4;
  localparam int ST_START  = 5;
  localparam int ST_RWVAL  = 6;
  // link to register side event toggles
  localparam int EV_RX    = 0;
  localparam int EV_MATCH = 1;
  localparam int EV_TXED  = 2;
  localparam int EV_START = 3;
  localparam int EV_STOP  = 4;
  localparam int EV_NACK  = 5;
  localparam int EV_UA    = 6;
  localparam int EV_DONE  = 7;
  localparam int EV_W     = 8;
  localparam int ADDR_W   = 10;
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [7:0]        BYTE_RST = 8'h00;
  localparam logic [4:0]        TEN_HDR  = 5'h1E;
  localparam logic [3:0]        TX_BITS  = 4'h8;
  localparam logic [3:0]        RX_BITS  = 4'h7;
  typedef enum logic [2:0] {
    IPSF_CMD_COND = 3'h1,
    IPSF_CMD_TX   = 3'h2,
    IPSF_CMD_BITS = 3'h4
  } ipsf_cmd_e;
endpackage

// File: src/ipsf_sync.sv
// two-flop synchroniser for levels and event toggles
`timescale 1ns/1ps
`default_nettype none
module ipsf_sync #(
  parameter int          WIDTH = 1,
  parameter logic [63:0] INIT  = 64'h0000_0000_0000_0000
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT[WIDTH-1:0];
      q        <= INIT[WIDTH-1:0];
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // ipsf_sync
`default_nettype wire

// File: src/ipsf_top.sv
// serial port status flags with AHB-Lite registers and an I2C link engine
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ipsf_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);
  typedef enum logic [8:0] {
    LS_IDLE  = 9'h001,
    LS_ADDR  = 9'h002,
    LS_ADDR2 = 9'h004,
    LS_ACKO  = 9'h008,
    LS_RX    = 9'h010,
    LS_TX    = 9'h020,
    LS_ACKI  = 9'h040,
    LS_MCOND = 9'h080,
    LS_MBIT  = 9'h100
  } ipsf_link_e;

  // register side state
  logic                     wr_pend_reg;
  logic [7:0]               wr_ofs_reg;
  logic                     master_reg;
  logic                     ten_reg;
  logic                     ackv_reg;
  logic [ipsf_pkg::EN_W-1:0] en_reg;
  logic [ipsf_pkg::ADDR_W-1:0] addr_reg;
  logic [7:0]               buf_reg;
  logic                     bf_reg;
  logic                     ua_reg;
  logic                     tip_reg;
  logic                     rw_reg;
  logic                     rw_valid_reg;
  logic                     start_seen_reg;
  logic                     stop_seen_reg;
  logic [2:0]               cmd_reg;
  logic                     cmd_tgl_reg;
  logic [ipsf_pkg::EV_W-1:0] ev_q;
  logic [ipsf_pkg::EV_W-1:0] ev_prev_reg;
  logic [ipsf_pkg::EV_W-1:0] ev_p;
  logic                     rd_go;
  logic                     wr_ctrl;
  logic                     wr_data;
  logic                     wr_addr;
  logic                     rd_data;
  logic                     active;
  logic                     xmit_mode;
  logic [31:0]              status;
  logic [ipsf_pkg::EN_W-1:0] en_pick;

  // link side state
  ipsf_link_e               lst;
  ipsf_link_e               after_reg;
  logic                     lrst_n;
  logic [1:0]               pins_q;
  logic [ipsf_pkg::ADDR_W+5:0] lvl_q;
  logic                     scl_s;
  logic                     sda_s;
  logic                     scl_prev_reg;
  logic                     sda_prev_reg;
  logic [3:0]               cnt_reg;
  logic [1:0]               ph_reg;
  logic [7:0]               sh_reg;
  logic [7:0]               rx_byte_reg;
  logic                     rw_l_reg;
  logic                     ack_go_reg;
  logic                     ten_hi_reg;
  logic                     nack_l_reg;
  logic                     cmd_seen_reg;
  logic                     sh_rcv_reg;
  logic [2:0]               mcode_reg;
  logic                     sda_oe_reg;
  logic                     scl_oe_reg;
  logic [ipsf_pkg::EV_W-1:0] ev_tgl_reg;
  logic [ipsf_pkg::EV_W-1:0] ev_set;
  logic                     rise;
  logic                     fall;
  logic                     l_start;
  logic                     l_stop;
  logic                     last_bit;
  logic [7:0]               byte_in;
  logic                     m7;
  logic                     mhi;
  logic                     mlo;
  logic                     addr_hit;
  logic                     mdone;
  logic [3:0]               mlast;
  logic                     lm;
  logic                     lten;
  logic                     lackv;
  logic                     lbf;
  logic                     lcmd;
  logic [ipsf_pkg::ADDR_W-1:0] laddr;

  // ---------------- AHB-Lite slave, zero wait states ----------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_go     = hsel && hready && htrans[1] && !hwrite;
  assign rd_data   = rd_go && (haddr[7:0] == ipsf_pkg::DATA_OFS);
  assign wr_ctrl   = wr_pend_reg && (wr_ofs_reg == ipsf_pkg::CTRL_OFS);
  assign wr_data   = wr_pend_reg && (wr_ofs_reg == ipsf_pkg::DATA_OFS);
  assign wr_addr   = wr_pend_reg && (wr_ofs_reg == ipsf_pkg::ADDR_OFS);
  assign active    = tip_reg || (|en_reg);
  assign xmit_mode = master_reg ? tip_reg : (rw_reg && rw_valid_reg);

  always_comb begin
    status = 32'h0000_0000;
    status[ipsf_pkg::ST_BF]     = bf_reg;
    status[ipsf_pkg::ST_UA]     = ua_reg;
    status[ipsf_pkg::ST_RW]     = master_reg ? tip_reg : rw_reg;
    status[ipsf_pkg::ST_ACTIVE] = active;
    status[ipsf_pkg::ST_STOP]   = stop_seen_reg;
    status[ipsf_pkg::ST_START]  = start_seen_reg;
    status[ipsf_pkg::ST_RWVAL]  = rw_valid_reg;
  end

  // only the highest priority enable of a write is taken
  always_comb begin
    en_pick = '0;
    for (int i = ipsf_pkg::EN_W - 1; i >= 0; i--) begin
      if (hwdata[ipsf_pkg::CTRL_EN_LSB + i]) begin
        en_pick = '0;
        en_pick[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 8'h00;
      hrdata      <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
      wr_ofs_reg  <= haddr[7:0];
      if (rd_go) begin
        case (haddr[7:0])
          ipsf_pkg::CTRL_OFS: hrdata <= {23'h00_0000, en_reg, 1'b0, ackv_reg, ten_reg, master_reg};
          ipsf_pkg::STATUS_OFS: hrdata <= status;
          ipsf_pkg::DATA_OFS: hrdata <= {24'h00_0000, buf_reg};
          ipsf_pkg::ADDR_OFS: hrdata <= {22'h00_0000, addr_reg};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register and master command issue
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      master_reg  <= 1'b0;
      ten_reg     <= 1'b0;
      ackv_reg    <= 1'b0;
      en_reg      <= '0;
      tip_reg     <= 1'b0;
      cmd_reg     <= 3'h0;
      cmd_tgl_reg <= 1'b0;
      addr_reg    <= ipsf_pkg::ADDR_RST;
    end else begin
      if (wr_addr) begin
        addr_reg <= hwdata[ipsf_pkg::ADDR_W-1:0];
      end
      if (wr_ctrl) begin
        master_reg <= hwdata[ipsf_pkg::CTRL_MASTER];
        ten_reg    <= hwdata[ipsf_pkg::CTRL_TEN];
        ackv_reg   <= hwdata[ipsf_pkg::CTRL_ACKV];
      end
      // a new request while active is dropped, even in the cycle the running one finishes
      if (wr_ctrl && master_reg && !active && (|en_pick)) begin
        en_reg      <= en_pick;
        cmd_reg     <= (en_pick[ipsf_pkg::EN_RCV] || en_pick[ipsf_pkg::EN_ACK]) ?
                       ipsf_pkg::IPSF_CMD_BITS : ipsf_pkg::IPSF_CMD_COND;
        cmd_tgl_reg <= !cmd_tgl_reg;
      end else if (wr_data && master_reg && !active) begin
        tip_reg     <= 1'b1;
        cmd_reg     <= ipsf_pkg::IPSF_CMD_TX;
        cmd_tgl_reg <= !cmd_tgl_reg;
      end else if (ev_p[ipsf_pkg::EV_DONE]) begin
        en_reg  <= '0;
        tip_reg <= 1'b0;
      end
    end
  end

  // status flags; a hardware set wins over a clear, except stop_seen_reg, which a start in the same cycle clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_reg        <= ipsf_pkg::BYTE_RST;
      bf_reg         <= 1'b0;
      ua_reg         <= 1'b0;
      rw_reg         <= 1'b0;
      rw_valid_reg   <= 1'b0;
      start_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b0;
      ev_prev_reg    <= '0;
    end else begin
      ev_prev_reg <= ev_q;
      if (ev_p[ipsf_pkg::EV_RX]) begin
        buf_reg <= rx_byte_reg;
      end else if (wr_data && (!master_reg || !active)) begin
        buf_reg <= hwdata[7:0];
      end
      if (ev_p[ipsf_pkg::EV_RX] || (wr_data && (!master_reg || !active))) begin
        bf_reg <= 1'b1;
      end else if (ev_p[ipsf_pkg::EV_TXED] || (rd_data && !xmit_mode)) begin
        bf_reg <= 1'b0;
      end
      if (ev_p[ipsf_pkg::EV_UA] && ten_reg) begin
        ua_reg <= 1'b1;
      end else if (wr_addr) begin
        ua_reg <= 1'b0;
      end
      if (ev_p[ipsf_pkg::EV_MATCH]) begin
        rw_reg       <= rw_l_reg;
        rw_valid_reg <= 1'b1;
      end else if (ev_p[ipsf_pkg::EV_START] || ev_p[ipsf_pkg::EV_STOP] ||
                   ev_p[ipsf_pkg::EV_NACK]) begin
        rw_valid_reg <= 1'b0;
      end
      if (ev_p[ipsf_pkg::EV_START]) begin
        start_seen_reg <= 1'b1;
        stop_seen_reg  <= 1'b0;
      end else if (ev_p[ipsf_pkg::EV_STOP]) begin
        start_seen_reg <= 1'b0;
        stop_seen_reg  <= 1'b1;
      end
    end
  end

  // ---------------- clock crossings ----------------
  // link data (rx_byte_reg, rw_l_reg) changes on the same link_clk edge as its toggle and is stable once the toggle is synchronised, so it is read directly
  assign ev_p = ev_q ^ ev_prev_reg;

  ipsf_sync #(.WIDTH(ipsf_pkg::EV_W), .INIT(64'h0000_0000_0000_0000)) u_ev_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (ev_tgl_reg),
    .q     (ev_q)
  );

  ipsf_sync #(.WIDTH(1), .INIT(64'h0000_0000_0000_0000)) u_lrst_sync (
    .clk   (link_clk),
    .rst_n (hresetn),
    .d     (1'b1),
    .q     (lrst_n)
  );

  // pins idle high, so the synchroniser starts high to avoid a false edge
  ipsf_sync #(.WIDTH(2), .INIT(64'h0000_0000_0000_0003)) u_pin_sync (
    .clk   (link_clk),
    .rst_n (lrst_n),
    .d     ({scl_in, sda_in}),
    .q     (pins_q)
  );

  // the slave address is quasi-static: change it only while the link is idle
  ipsf_sync #(.WIDTH(ipsf_pkg::ADDR_W + 6), .INIT(64'h0000_0000_0000_0000)) u_lvl_sync (
    .clk   (link_clk),
    .rst_n (lrst_n),
    .d     ({addr_reg, cmd_tgl_reg, bf_reg, ackv_reg, ten_reg, master_reg, 1'b0}),
    .q     (lvl_q)
  );

  assign {laddr, lcmd, lbf, lackv, lten, lm} = lvl_q[ipsf_pkg::ADDR_W+5:1];
  assign {scl_s, sda_s} = pins_q;

  // ---------------- link engine ----------------
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe   = scl_oe_reg;
  assign sda_oe   = sda_oe_reg;
  assign rise     = scl_s && !scl_prev_reg;
  assign fall     = !scl_s && scl_prev_reg;
  assign l_start  = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign l_stop   = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  assign byte_in  = {sh_reg[6:0], sda_s};
  assign last_bit = rise && (cnt_reg == 4'h7);
  assign m7       = byte_in[7:1] == laddr[6:0];
  assign mhi      = (byte_in[7:3] == ipsf_pkg::TEN_HDR) && (byte_in[2:1] == laddr[9:8]);
  assign mlo      = byte_in == laddr[7:0];
  assign addr_hit = last_bit && ((lst == LS_ADDR2 && mlo) ||
                    (lst == LS_ADDR && (lten ? (mhi && byte_in[0] && ten_hi_reg) : m7)));
  // a receive takes eight bits, an ack sequence only one
  assign mlast    = (mcode_reg == ipsf_pkg::IPSF_CMD_TX) ? ipsf_pkg::TX_BITS :
                    (sh_rcv_reg ? ipsf_pkg::RX_BITS : 4'h0);
  assign mdone    = (ph_reg == 2'h3) &&
                    (lst == LS_MCOND || (lst == LS_MBIT && cnt_reg == mlast));

  always_comb begin
    ev_set = '0;
    ev_set[ipsf_pkg::EV_START] = l_start;
    ev_set[ipsf_pkg::EV_STOP]  = l_stop;
    ev_set[ipsf_pkg::EV_MATCH] = addr_hit;
    ev_set[ipsf_pkg::EV_UA]    = lten && last_bit && ((lst == LS_ADDR2 && mlo) ||
                                 (lst == LS_ADDR && mhi && !byte_in[0]));
    ev_set[ipsf_pkg::EV_RX]    = (lst == LS_RX && last_bit && !lbf) ||
                                 (mdone && lst == LS_MBIT && sh_rcv_reg);
    ev_set[ipsf_pkg::EV_TXED]  = (lst == LS_TX && last_bit) ||
                                 (mdone && mcode_reg == ipsf_pkg::IPSF_CMD_TX);
    ev_set[ipsf_pkg::EV_NACK]  = (lst == LS_ACKI && rise && sda_s) ||
                                 (mdone && mcode_reg == ipsf_pkg::IPSF_CMD_TX && nack_l_reg);
    ev_set[ipsf_pkg::EV_DONE]  = mdone && lm;
  end

  // no clock stretching or arbitration: the master assumes it owns the bus
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lst          <= LS_IDLE;
      after_reg    <= LS_IDLE;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      cnt_reg      <= 4'h0;
      ph_reg       <= 2'h0;
      sh_reg       <= ipsf_pkg::BYTE_RST;
      rx_byte_reg  <= ipsf_pkg::BYTE_RST;
      rw_l_reg     <= 1'b0;
      ack_go_reg   <= 1'b0;
      ten_hi_reg   <= 1'b0;
      nack_l_reg   <= 1'b0;
      cmd_seen_reg <= 1'b0;
      mcode_reg    <= 3'h0;
      sh_rcv_reg   <= 1'b0;
      sda_oe_reg   <= 1'b0;
      scl_oe_reg   <= 1'b0;
      ev_tgl_reg   <= '0;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      ev_tgl_reg   <= ev_tgl_reg ^ ev_set;
      ph_reg       <= ph_reg + 2'h1;
      if (addr_hit) begin
        rw_l_reg <= (lst == LS_ADDR2) ? 1'b0 : byte_in[0];
      end
      if (l_stop) begin
        ten_hi_reg <= 1'b0;
      end else if (lst == LS_ADDR2 && last_bit && mlo) begin
        ten_hi_reg <= 1'b1;
      end
      if (lm && lst == LS_IDLE && lcmd != cmd_seen_reg) begin
        cmd_seen_reg <= lcmd;
        mcode_reg    <= cmd_reg;
        sh_reg       <= buf_reg;
        sh_rcv_reg   <= en_reg[ipsf_pkg::EN_RCV];
        nack_l_reg   <= 1'b0;
        cnt_reg      <= 4'h0;
        ph_reg       <= 2'h0;
        lst          <= (cmd_reg == ipsf_pkg::IPSF_CMD_COND) ? LS_MCOND : LS_MBIT;
      end else if (!lm && l_start) begin
        lst        <= LS_ADDR;
        cnt_reg    <= 4'h0;
        sda_oe_reg <= 1'b0;
      end else if (!lm && l_stop) begin
        lst        <= LS_IDLE;
        sda_oe_reg <= 1'b0;
      end else begin
        case (lst)
          LS_ADDR, LS_ADDR2, LS_RX: begin
            if (rise) begin
              sh_reg  <= byte_in;
              cnt_reg <= cnt_reg + 4'h1;
            end
            if (last_bit) begin
              ph_reg <= 2'h0;
              if (lst == LS_RX) begin
                ack_go_reg <= !lbf;
                after_reg  <= LS_RX;
                if (!lbf) begin
                  rx_byte_reg <= byte_in;
                end
              end else if (addr_hit) begin
                ack_go_reg <= 1'b1;
                after_reg  <= byte_in[0] && lst == LS_ADDR ? LS_TX : LS_RX;
              end else if (lten && lst == LS_ADDR && mhi && !byte_in[0]) begin
                ack_go_reg <= 1'b1;
                after_reg  <= LS_ADDR2;
              end else begin
                ack_go_reg <= 1'b0;
                after_reg  <= LS_IDLE;
              end
              lst <= LS_ACKO;
            end
          end
          LS_ACKO: begin
            ph_reg <= ph_reg;
            if (fall && ph_reg == 2'h0) begin
              sda_oe_reg <= ack_go_reg;
              ph_reg     <= 2'h1;
              lst        <= ack_go_reg ? LS_ACKO : LS_IDLE;
            end else if (fall) begin
              cnt_reg    <= 4'h0;
              lst        <= after_reg;
              sh_reg     <= buf_reg;
              sda_oe_reg <= (after_reg == LS_TX) ? !buf_reg[7] : 1'b0;
            end
          end
          LS_TX: begin
            if (rise) begin
              cnt_reg <= cnt_reg + 4'h1;
            end
            if (fall && cnt_reg == ipsf_pkg::TX_BITS) begin
              sda_oe_reg <= 1'b0;
              lst        <= LS_ACKI;
            end else if (fall) begin
              sh_reg     <= {sh_reg[6:0], 1'b0};
              sda_oe_reg <= !sh_reg[6];
            end
          end
          LS_ACKI: begin
            if (rise) begin
              ph_reg    <= 2'h1;
              after_reg <= LS_TX;
              lst       <= sda_s ? LS_IDLE : LS_ACKO;
            end
          end
          LS_MCOND: begin
            // start and restart: release data, release clock, data low, clock low
            // stop: data low, release clock, release data
            case (ph_reg)
              2'h0: sda_oe_reg <= en_reg[ipsf_pkg::EN_STOP];
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= !en_reg[ipsf_pkg::EN_STOP];
              default: begin
                scl_oe_reg <= !en_reg[ipsf_pkg::EN_STOP];
                lst        <= LS_IDLE;
              end
            endcase
          end
          LS_MBIT: begin
            case (ph_reg)
              2'h0: sda_oe_reg <= (mcode_reg == ipsf_pkg::IPSF_CMD_TX) ?
                                  (cnt_reg != ipsf_pkg::TX_BITS && !sh_reg[7]) :
                                  (!sh_rcv_reg && !lackv);
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: begin
                sh_reg <= byte_in;
                if (cnt_reg == ipsf_pkg::TX_BITS) begin
                  nack_l_reg <= sda_s;
                end
              end
              default: begin
                scl_oe_reg <= 1'b1;
                cnt_reg    <= cnt_reg + 4'h1;
                if (mdone) begin
                  lst <= LS_IDLE;
                  if (sh_rcv_reg) begin
                    rx_byte_reg <= sh_reg;
                  end
                end
              end
            endcase
          end
          default: begin
            lst <= LS_IDLE;
          end
        endcase
      end
    end
  end
endmodule // ipsf_top
`default_nettype wire

// File: testbench/ipsf_monitor.sv
// concurrent checks on the ports of the status flag block
`timescale 1ns/1ps
`default_nettype none
module ipsf_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        link_clk,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_st;
  logic wr_ctl;
  logic mst;
  logic ten;
  wire  rd_req = hsel && hready && htrans[1] && !hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_st  <= 1'b0;
      wr_ctl <= 1'b0;
    end else begin
      rd_st  <= rd_req && haddr[7:0] == ipsf_pkg::STATUS_OFS;
      wr_ctl <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == ipsf_pkg::CTRL_OFS;
    end
  end
  // mode bits mirrored from control writes so status reads can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) {ten, mst} <= 2'h0;
    else if (wr_ctl) {ten, mst} <= hwdata[1:0];
  end
  property p_ok; hresp == 1'b0; endproperty
  a_ok: assert property (p_ok) else $error("error response seen");
  property p_rdy; hreadyout == 1'b1; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state seen");
  property p_od; scl_out == 1'b0 && sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_rst; $rose(hresetn) |-> !scl_oe && !sda_oe; endproperty
  a_rst: assert property (p_rst) else $error("bus pulled after reset");
  property p_hold; !$past(rd_req) |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_rsv; rd_st |-> hrdata[31:7] == 25'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("unused status bits set");
  property p_act; rd_st && mst && hrdata[ipsf_pkg::ST_RW] |-> hrdata[ipsf_pkg::ST_ACTIVE]; endproperty
  a_act: assert property (p_act) else $error("transmit without active");
  property p_ua; rd_st && !ten |-> !hrdata[ipsf_pkg::ST_UA]; endproperty
  a_ua: assert property (p_ua) else $error("reload request outside ten-bit mode");
  c_bf: cover property (rd_st && hrdata[ipsf_pkg::ST_BF]);
  c_tx: cover property (rd_st && mst && hrdata[ipsf_pkg::ST_RW]);
  c_rd: cover property (rd_st && hrdata[ipsf_pkg::ST_RWVAL] && hrdata[ipsf_pkg::ST_RW]);
endmodule // ipsf_monitor
`default_nettype wire

// File: testbench/ipsf_peer.sv
// i2c peer: acknowledging target and slow bit-level controller
`timescale 1ns/1ps
`default_nettype none
module ipsf_peer (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_pd,
  output logic      sda_pd
);
  int         nbit = 0;
  logic       ack  = 1'b0;
  logic       drv  = 1'b0;
  logic       pull = 1'b0;
  logic [7:0] sh   = 8'h00;
  logic [7:0] last = 8'h00;
  // target ack is muted while this side controls the bus
  assign sda_pd = pull | (ack & !drv);
  initial scl_pd = 1'b0;
  always @(negedge sda) if (scl) nbit = 0;
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    nbit = nbit + 1;
    if (nbit % 9 == 8) last = sh;
  end
  always @(negedge scl) ack <= (nbit % 9 == 8);
  task automatic start();
    drv = 1'b1; pull = 1'b1; #500;
    scl_pd = 1'b1; #500;
  endtask
  task automatic restart();
    pull = 1'b0; #500;
    scl_pd = 1'b0; #500;
    start();
  endtask
  task automatic stop();
    pull = 1'b1; #500;
    scl_pd = 1'b0; #500;
    pull = 1'b0; #500;
    drv = 1'b0;
  endtask
  // sda moves 100 ns after scl falls so the synchronised pins never see sda change while scl is high
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      pull = !tx[i]; #500;
      scl_pd = 1'b0; #250;
      rx[i] = sda; #250;
      scl_pd = 1'b1; #100;
    end
  endtask
endmodule // ipsf_peer
`default_nettype wire

// File: testbench/testbench.sv
// testbench: register tasks, i2c peer and status flag scenarios
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        hclk = 1'b0;
  logic        link_clk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic        scl_out, scl_oe, sda_out, sda_oe, p_scl, p_sda;
  wire         scl = !(scl_oe | p_scl);
  wire         sda = !(sda_oe | p_sda);
  logic [8:0]  r;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  initial forever #2.5 hclk = !hclk;
  initial begin
    #17;
    forever #62.5 link_clk = !link_clk;
  end
  ipsf_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  ipsf_peer u_peer (.scl(scl), .sda(sda), .scl_pd(p_scl), .sda_pd(p_sda));
  task automatic test_done();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // the leading edge also gives the idle cycle a read after a write needs
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h00_0000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic st();
    rw(1'b0, ipsf_pkg::STATUS_OFS, 32'h0000_0000, d);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      st();
      n++;
    end while (d[ipsf_pkg::ST_ACTIVE] !== 1'b0 && n < 2000);
    chk(n < 2000, 1'b1);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'h0;
    hwrite = 1'b0; hwdata = 32'h0000_0000;
    repeat (3) @(posedge link_clk);
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge link_clk);
    rw(1'b0, 8'h10, 32'h0000_0000, d);
    chk(d, 32'h0000_0000);
    rw(1'b1, ipsf_pkg::ADDR_OFS, 32'h0000_0052, d);
    u_peer.start();
    u_peer.xfer({8'hA4, 1'b1}, r);
    chk(r[0], 1'b0);
    st();
    chk({d[6], d[2:0]}, 4'h8);
    u_peer.xfer({8'h5A, 1'b1}, r);
    st();
    chk({d[6], d[2:0]}, 4'h9);
    rw(1'b0, ipsf_pkg::DATA_OFS, 32'h0000_0000, d);
    chk(d, 32'h0000_005A);
    st();
    chk(d[0], 1'b0);
    rw(1'b1, ipsf_pkg::DATA_OFS, 32'h0000_00C3, d);
    st();
    chk(d[0], 1'b1);
    u_peer.restart();
    u_peer.xfer({8'hA5, 1'b1}, r);
    st();
    chk({d[6], d[2:0]}, 4'hD);
    u_peer.xfer(9'h1FF, r);
    chk(r[8:1], 8'hC3);
    st();
    chk({d[6], d[0]}, 2'h0);
    rw(1'b1, ipsf_pkg::CTRL_OFS, 32'h0000_0002, d);
    u_peer.stop();
    u_peer.start();
    u_peer.xfer({8'hF0, 1'b1}, r);
    u_peer.xfer({8'h52, 1'b1}, r);
    st();
    chk({r[0], d[6], d[2:0]}, 5'h0A);
    rw(1'b1, ipsf_pkg::ADDR_OFS, 32'h0000_0052, d);
    st();
    chk(d[1], 1'b0);
    u_peer.stop();
    rw(1'b1, ipsf_pkg::CTRL_OFS, 32'h0000_0001, d);
    rw(1'b1, ipsf_pkg::CTRL_OFS, 32'h0000_0011, d);
    st();
    chk({d[3], d[2]}, 2'h2);
    wait_idle();
    rw(1'b1, ipsf_pkg::DATA_OFS, 32'h0000_00A6, d);
    repeat (4) @(posedge link_clk);
    st();
    chk({d[3], d[2], d[0]}, 3'h7);
    wait_idle();
    chk({d[2], d[0]}, 2'h0);
    chk(u_peer.last, 8'hA6);
    rw(1'b1, ipsf_pkg::CTRL_OFS, 32'h0000_0041, d);
    wait_idle();
    test_done();
  end
endmodule // testbench
bind ipsf_top ipsf_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe));
`default_nettype wire
